// ---- hw/fms_sequencer.sv ----
/*
 feed move sequencer: queues feed commands and runs relative, masked sensor and output feeds.
 assumes commands arrive already decoded from the serial link, synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module fms_sequencer (
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst,
   // command port
   input  wire logic          cmd_valid,
   input  wire logic [1:0]    cmd_code,
   input  wire logic          cmd_has_param,
   input  wire logic [31:0]   cmd_param,
   input  wire logic [2:0]    cmd_sel,
   input  wire logic [1:0]    cmd_cond,
   output logic               cmd_ready,
   output logic               cmd_reject,
   // stored settings
   input  wire logic [31:0]   move_length_setting,
   input  wire logic [31:0]   secondary_span,
   input  wire logic [15:0]   target_speed,
   input  wire logic [15:0]   speedup_rate,
   input  wire logic [15:0]   slowdown_rate,
   input  wire logic [11:0]   analog_threshold,
   // terminals
   input  wire logic [2:0]    term_current,
   input  wire logic [11:0]   analog_sense_input,
   output logic               gp_out_current,
   // motion
   output logic               step_out,
   output logic               dir_ccw,
   output logic               busy,
   output logic               move_done
);
   function automatic logic [30:0] mag(input logic [31:0] v);
      logic [31:0] n;
      n = v[31] ? (32'h0 - v) : v;
      return n[30:0];
   endfunction

   logic [fms_pkg::QW-1:0]  q_mem [fms_pkg::QDEPTH];
   logic [1:0]              wp_reg, wp_next, rp_reg, rp_next;
   logic [2:0]              cnt_reg, cnt_next;
   logic                    rdy_next, rej_next, push, pop, bad;
   fms_pkg::fms_state_t     st_reg, st_next;
   logic [fms_pkg::QW-1:0]  head;
   logic [1:0]              kind_reg, kind_next, cond_reg, cond_next;
   logic [2:0]              sel_reg, sel_next;
   logic [31:0]             trav_reg, trav_next;
   logic                    trig_reg, trig_next, odone_reg, odone_next;
   logic                    open_reg, open_next, dir_next, mdone_next;
   logic                    lvl, prev_reg, hit, armed;
   logic                    g_start, g_retarget, g_endless, g_step, g_done;
   logic [30:0]             g_len;

   // admission: output feed only on output 1, sensor feed only on 1 to 4
   always_comb
   begin
      bad = (cmd_code == fms_pkg::CMD_MASK &&
             (cmd_sel < fms_pkg::SEL_FIRST || cmd_sel > fms_pkg::SEL_ANALOG)) ||
            (cmd_code == fms_pkg::CMD_OUT && cmd_sel != fms_pkg::OUT_ONLY) ||
            (cmd_code > fms_pkg::CMD_OUT);
      push = cmd_valid && cmd_ready && !bad;
      rej_next = cmd_valid && cmd_ready && bad;
      pop = (st_reg == fms_pkg::FMS_IDLE) && (cnt_reg != fms_pkg::CNT_RST);
      wp_next = push ? wp_reg + 2'h1 : wp_reg;
      rp_next = pop ? rp_reg + 2'h1 : rp_reg;
      cnt_next = cnt_reg + {2'h0, push} - {2'h0, pop};
      rdy_next = cnt_next < 3'(fms_pkg::QDEPTH);
   end

   always_ff @(posedge mclk)
   begin
      if (push) q_mem[wp_reg] <= {cmd_code, cmd_has_param, cmd_param, cmd_sel, cmd_cond};
   end

   // queue pointers
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wp_reg <= 2'h0; rp_reg <= 2'h0; cnt_reg <= fms_pkg::CNT_RST;
         cmd_ready <= 1'b1; cmd_reject <= 1'b0;
      end
      else
      begin
         wp_reg <= wp_next; rp_reg <= rp_next; cnt_reg <= cnt_next;
         cmd_ready <= rdy_next; cmd_reject <= rej_next;
      end
   end

   // energized terminal is logic low; analog compare
   always_comb
   begin
      if (sel_reg == fms_pkg::SEL_ANALOG)
         lvl = analog_sense_input > analog_threshold;
      else if (sel_reg >= fms_pkg::SEL_FIRST && sel_reg < fms_pkg::SEL_ANALOG)
         lvl = !term_current[sel_reg[1:0] - 2'h1];
      else
         lvl = 1'b1;
      case (cond_reg)
         fms_pkg::COND_L: hit = !lvl;
         fms_pkg::COND_H: hit = lvl;
         fms_pkg::COND_F: hit = prev_reg && !lvl;
         default:         hit = !prev_reg && lvl;
      endcase
   end

   // sequencing of one move
   always_comb
   begin
      head = q_mem[rp_reg];
      st_next = st_reg; kind_next = kind_reg; sel_next = sel_reg; cond_next = cond_reg;
      trav_next = trav_reg; trig_next = trig_reg; odone_next = odone_reg;
      open_next = open_reg; dir_next = dir_ccw; mdone_next = 1'b0;
      g_start = 1'b0; g_retarget = 1'b0; g_endless = 1'b0; g_len = 31'h0;
      armed = trav_reg >= secondary_span;
      case (st_reg)
         fms_pkg::FMS_IDLE:
            if (pop)
            begin
               st_next = fms_pkg::FMS_RUN;
               kind_next = head[39:38]; sel_next = head[4:2]; cond_next = head[1:0];
               trav_next = fms_pkg::TRAV_RST; trig_next = 1'b0; odone_next = 1'b0;
               g_start = 1'b1;
               // stored or supplied length and its sign
               if (head[39:38] == fms_pkg::CMD_REL && head[37])
               begin
                  g_len = mag(head[36:5]);
                  dir_next = head[36];
               end
               else
               begin
                  g_len = mag(move_length_setting);
                  dir_next = move_length_setting[31];
               end
               // sensor feed runs open ended until the hit
               g_endless = head[39:38] == fms_pkg::CMD_MASK;
            end
         fms_pkg::FMS_RUN:
         begin
            if (g_step) trav_next = trav_reg + 32'h1;
            // sensor seen only past the mask span, then run on
            if (kind_reg == fms_pkg::CMD_MASK && !trig_reg && armed && hit)
            begin
               trig_next = 1'b1;
               g_retarget = 1'b1;
               g_len = mag(move_length_setting);
            end
            // output set once at the span point
            if (kind_reg == fms_pkg::CMD_OUT && !odone_reg && armed)
            begin
               odone_next = 1'b1;
               open_next = cond_reg == fms_pkg::COND_H;
            end
            if (g_done)
            begin
               st_next = fms_pkg::FMS_IDLE;
               mdone_next = 1'b1;
            end
         end
         default: st_next = fms_pkg::FMS_IDLE;
      endcase
   end

   // sequencer registers
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_reg <= fms_pkg::FMS_IDLE; kind_reg <= fms_pkg::CMD_REL; sel_reg <= 3'h0;
         cond_reg <= fms_pkg::COND_L; trav_reg <= fms_pkg::TRAV_RST; trig_reg <= 1'b0;
         odone_reg <= 1'b0; open_reg <= fms_pkg::GP_OUT_RST; dir_ccw <= 1'b0;
         move_done <= 1'b0; prev_reg <= 1'b1; gp_out_current <= 1'b0; busy <= 1'b0;
      end
      else
      begin
         st_reg <= st_next; kind_reg <= kind_next; sel_reg <= sel_next;
         cond_reg <= cond_next; trav_reg <= trav_next; trig_reg <= trig_next;
         odone_reg <= odone_next; open_reg <= open_next; dir_ccw <= dir_next;
         move_done <= mdone_next; prev_reg <= lvl;
         gp_out_current <= !open_next;
         busy <= st_next == fms_pkg::FMS_RUN;
      end
   end

   // speed and rates taken at start
   fms_step_gen u_gen (
      .mclk       (mclk),
      .rst        (rst),
      .start      (g_start),
      .retarget   (g_retarget),
      .endless    (g_endless),
      .len        (g_len),
      .speed      (target_speed),
      .accel      (speedup_rate),
      .decel      (slowdown_rate),
      .step_pulse (g_step),
      .busy       (),
      .done       (g_done)
   );
   assign step_out = g_step;

   // checks
   a_queue_order: assert property (@(posedge mclk) disable iff (rst)
      g_start |-> st_reg == fms_pkg::FMS_IDLE && cnt_reg != 3'h0) else $error("start not from queue");
   a_ready_full: assert property (@(posedge mclk) disable iff (rst)
      cnt_reg == 3'h4 |-> !cmd_ready) else $error("ready while full");
   a_reject_bad: assert property (@(posedge mclk) disable iff (rst)
      cmd_valid && cmd_ready && cmd_code == fms_pkg::CMD_OUT && cmd_sel != 3'h1 |=> cmd_reject)
      else $error("bad output number taken");
   a_rel_param: assert property (@(posedge mclk) disable iff (rst)
      g_start && head[39:38] == fms_pkg::CMD_REL && head[37] |=> dir_ccw == $past(head[36]))
      else $error("supplied sign ignored");
   a_dir_stored: assert property (@(posedge mclk) disable iff (rst)
      g_start && !(head[39:38] == fms_pkg::CMD_REL && head[37])
      |=> dir_ccw == $past(move_length_setting[31])) else $error("stored sign ignored");
   a_mask_hold: assert property (@(posedge mclk) disable iff (rst)
      kind_reg == fms_pkg::CMD_MASK && trav_reg < secondary_span |-> !g_retarget)
      else $error("sensor seen inside mask");
   a_mask_runon: assert property (@(posedge mclk) disable iff (rst)
      g_retarget |-> !trig_reg ##1 trig_reg && u_gen.rem_reg == mag($past(move_length_setting)))
      else $error("run-on length wrong");
   a_out_point: assert property (@(posedge mclk) disable iff (rst)
      $rose(odone_reg) |-> $past(trav_reg) >= $past(secondary_span)) else $error("output early");
   a_out_level: assert property (@(posedge mclk) disable iff (rst)
      $rose(odone_reg) |-> gp_out_current == ($past(cond_reg) != fms_pkg::COND_H))
      else $error("output level wrong");
   a_done_idle: assert property (@(posedge mclk) disable iff (rst)
      g_done |=> !busy ##1 1'b1) else $error("busy after done");
   c_rel_move: cover property (@(posedge mclk) kind_reg == fms_pkg::CMD_REL && move_done);
   c_mask_hit: cover property (@(posedge mclk) g_retarget);
   c_out_set: cover property (@(posedge mclk) $rose(odone_reg));
endmodule // fms_sequencer
`default_nettype wire

// ---- inc/fms_pkg.sv ----
/*
 feed move sequencer package: command codes, conditions, sensor numbers, widths, reset values.
 assumes nothing of its surroundings.
*/
`default_nettype none
package fms_pkg;
   // command kinds
   localparam logic [1:0] CMD_REL  = 2'h0; // relative feed
   localparam logic [1:0] CMD_MASK = 2'h1; // masked feed to sensor
   localparam logic [1:0] CMD_OUT  = 2'h2; // relative feed with output change
   // condition letters
   localparam logic [1:0] COND_L = 2'h0;
   localparam logic [1:0] COND_H = 2'h1;
   localparam logic [1:0] COND_F = 2'h2;
   localparam logic [1:0] COND_R = 2'h3;
   // sensor numbers
   localparam logic [2:0] SEL_FIRST  = 3'h1;
   localparam logic [2:0] SEL_ANALOG = 3'h4;
   localparam logic [2:0] OUT_ONLY   = 3'h1;
   // widths and depths
   localparam int QDEPTH = 4;
   localparam int QW     = 40;
   localparam int AW     = 12;
   // reset values
   localparam logic       GP_OUT_RST = 1'h1; // output open after reset
   localparam logic [2:0] CNT_RST    = 3'h0;
   localparam logic [31:0] TRAV_RST  = 32'h0;
   typedef enum logic {FMS_IDLE, FMS_RUN} fms_state_t;
endpackage
`default_nettype wire

// ---- hw/fms_step_gen.sv ----
/*
 step pulse generator with speedup, cruise and slowdown; runs a set step count or endless
 until given a remaining count. assumes settings stay steady while a move starts.
*/
`timescale 1ns/1ps
`default_nettype none
module fms_step_gen (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // move control
   input  wire logic        start,
   input  wire logic        retarget,
   input  wire logic        endless,
   input  wire logic [30:0] len,
   input  wire logic [15:0] speed,
   input  wire logic [15:0] accel,
   input  wire logic [15:0] decel,
   // status
   output logic             step_pulse,
   output logic             busy,
   output logic             done
);
   logic [31:0] vel_reg, vel_next;
   logic [15:0] ph_reg, ph_next;
   logic [30:0] rem_reg, rem_next, ramp_reg, ramp_next;
   logic        end_reg, end_next, busy_next, step_next, done_next;
   logic [15:0] spd_reg, spd_next, acc_reg, acc_next, dec_reg, dec_next;
   logic [16:0] sum, up, dn;

   // profile, phase and remaining count
   always_comb
   begin
      vel_next = vel_reg; ph_next = ph_reg; rem_next = rem_reg; ramp_next = ramp_reg;
      end_next = end_reg; busy_next = busy; step_next = 1'b0; done_next = 1'b0;
      spd_next = spd_reg; acc_next = acc_reg; dec_next = dec_reg;
      sum = {1'b0, ph_reg} + {1'b0, vel_reg[31:16]};
      up = {1'b0, vel_reg[31:16]} + {1'b0, acc_reg};
      dn = {1'b0, vel_reg[31:16]} - {1'b0, dec_reg};
      if (start)
      begin
         busy_next = 1'b1; rem_next = len; end_next = endless; vel_next = 32'h0;
         ph_next = 16'h0; ramp_next = 31'h0;
         spd_next = speed; acc_next = accel; dec_next = decel;
      end
      else if (busy)
      begin
         if (retarget)
         begin
            rem_next = len;
            end_next = 1'b0;
         end
         else if (!end_reg && rem_reg == 31'h0)
         begin
            busy_next = 1'b0;
            done_next = 1'b1;
         end
         else
         begin
            ph_next = sum[15:0];
            if (sum[16])
            begin
               step_next = 1'b1;
               if (!end_reg) rem_next = rem_reg - 31'h1;
               if (vel_reg[31:16] < spd_reg) ramp_next = ramp_reg + 31'h1;
            end
            // slow down once the remaining count falls to the ramp length
            // rates act on the whole speed part, so a ramp takes few cycles; floor is speed 1
            if (!end_reg && rem_reg <= ramp_reg)
               vel_next = (vel_reg[31:16] > dec_reg) ? {dn[15:0], vel_reg[15:0]}
                                                     : {16'h1, 16'h0};
            else if (up >= {1'b0, spd_reg})
               vel_next = {spd_reg, 16'h0};
            else
               vel_next = {up[15:0], vel_reg[15:0]};
         end
      end
   end

   // registers
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         vel_reg <= 32'h0; ph_reg <= 16'h0; rem_reg <= 31'h0; ramp_reg <= 31'h0;
         end_reg <= 1'b0; busy <= 1'b0; step_pulse <= 1'b0; done <= 1'b0;
         spd_reg <= 16'h0; acc_reg <= 16'h0; dec_reg <= 16'h0;
      end
      else
      begin
         vel_reg <= vel_next; ph_reg <= ph_next; rem_reg <= rem_next; ramp_reg <= ramp_next;
         end_reg <= end_next; busy <= busy_next; step_pulse <= step_next; done <= done_next;
         spd_reg <= spd_next; acc_reg <= acc_next; dec_reg <= dec_next;
      end
   end
endmodule // fms_step_gen
`default_nettype wire

// ---- test/fms_host_model.sv ----
/*
 host model: offers one feed command at a time on the command port.
 assumes the sequencer takes a command at a rising edge with valid and ready high.
*/
`timescale 1ns/1ps
`default_nettype none
module fms_host_model (
   // clock
   input  wire logic        mclk,
   // command port
   output logic             cmd_valid,
   output logic [1:0]       cmd_code,
   output logic             cmd_has_param,
   output logic [31:0]      cmd_param,
   output logic [2:0]       cmd_sel,
   output logic [1:0]       cmd_cond,
   input  wire logic        cmd_ready
);
   // idle port at time zero
   initial
   begin
      cmd_valid = 1'b0;
      {cmd_code, cmd_has_param, cmd_param, cmd_sel, cmd_cond} = '0;
   end
   task automatic send(input logic [1:0] c, input logic hp, input logic [31:0] p,
                       input logic [2:0] s, input logic [1:0] k);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      {cmd_code, cmd_has_param, cmd_param, cmd_sel, cmd_cond} <= {c, hp, p, s, k};
      @(posedge mclk);
      while (cmd_ready !== 1'b1)
         @(posedge mclk);
      cmd_valid <= 1'b0;
      // released fields show inverted values
      {cmd_code, cmd_has_param, cmd_param, cmd_sel, cmd_cond} <= ~{c, hp, p, s, k};
   endtask
endmodule // fms_host_model
`default_nettype wire

// ---- test/testbench.sv ----
/*
 bench for the feed move sequencer: random and corner feeds, steps counted per move.
 assumes the host model owns the command port; the bench drives settings and terminals.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        mclk, rst, cmd_valid, cmd_has_param, cmd_ready, cmd_reject;
   logic [1:0]  cmd_code, cmd_cond;
   logic [2:0]  cmd_sel, term_current;
   logic [31:0] cmd_param, move_length_setting, secondary_span, rnd, scnt, len;
   logic [15:0] target_speed, speedup_rate, slowdown_rate;
   logic [11:0] analog_threshold, analog_sense_input;
   logic        gp_out_current, step_out, dir_ccw, busy, move_done;
   logic [31:0] got_q[$], exp_q[$];
   logic [1:0]  bad_code[4];
   logic [2:0]  bad_sel[4];
   int          error_cnt, n_tests, cyc, w;

   // 8 ns clock
   initial mclk = 1'b0;
   always #4 mclk = ~mclk;

   fms_host_model host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_has_param(cmd_has_param), .cmd_param(cmd_param), .cmd_sel(cmd_sel),
      .cmd_cond(cmd_cond), .cmd_ready(cmd_ready));
   fms_sequencer DUT (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_has_param(cmd_has_param), .cmd_param(cmd_param), .cmd_sel(cmd_sel),
      .cmd_cond(cmd_cond), .cmd_ready(cmd_ready), .cmd_reject(cmd_reject),
      .move_length_setting(move_length_setting), .secondary_span(secondary_span),
      .target_speed(target_speed), .speedup_rate(speedup_rate),
      .slowdown_rate(slowdown_rate), .analog_threshold(analog_threshold),
      .term_current(term_current), .analog_sense_input(analog_sense_input),
      .gp_out_current(gp_out_current), .step_out(step_out), .dir_ccw(dir_ccw),
      .busy(busy), .move_done(move_done));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected word: direction on top, step count below
   function automatic logic [31:0] exp_word(input logic [31:0] l);
      return {l[31], l[31] ? 31'(-l) : l[30:0]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // random speed, rates equal so the ramp ends in one cycle
   task automatic set_spd;
      rnd = lfsr(rnd);
      target_speed <= {4'h1, rnd[11:0]};
      speedup_rate <= {4'h1, rnd[11:0]};
      slowdown_rate <= {4'h1, rnd[11:0]};
      @(posedge mclk);
   endtask

   // sensor level; analog equal to threshold reads low
   task automatic set_lvl(input logic [2:0] s, input logic lvl);
      if (s == fms_pkg::SEL_ANALOG)
         analog_sense_input <= lvl ? analog_threshold + 12'h001 : analog_threshold;
      else
         term_current[s - 3'h1] <= ~lvl;
   endtask

   // wait for the step that brings the count to span or beyond
   task automatic wait_span(input logic exact);
      w = 0;
      while (!(step_out === 1'b1 && (exact ? scnt + 1 == secondary_span
             : scnt + 1 >= secondary_span)) && w < 5000)
      begin
         @(posedge mclk);
         w++;
      end
      if (w >= 5000)
      begin
         error_cnt++;
         $display("BAD t=%0t span wait timeout got=%h exp=%h", $time, scnt, secondary_span);
      end
   endtask

   task automatic drain(input string name);
      int t;
      t = 0;
      while (got_q.size() < exp_q.size() && t < 20000)
      begin
         @(posedge mclk);
         t++;
      end
      repeat (4) @(posedge mclk);
      chk(32'(got_q.size()), 32'(exp_q.size()));
      while (exp_q.size() > 0 && got_q.size() > 0)
         chk(got_q.pop_front(), exp_q.pop_front());
      got_q.delete();
      exp_q.delete();
      $display("test %s done, errors %0d", name, error_cnt);
   endtask

   // steps per move, and a ceiling of 40000 cycles, well above the expected run
   always @(posedge mclk)
   begin
      cyc++;
      if (move_done === 1'b1)
      begin
         got_q.push_back({dir_ccw, scnt[30:0] + {30'h0, step_out}});
         scnt <= 32'h0;
      end
      else if (step_out === 1'b1)
         scnt <= scnt + 32'h1;
      if (cyc == 40000)
      begin
         error_cnt++;
         finish_test();
      end
   end

   // main sequence
   initial
   begin
      {rst, rnd, scnt, cyc, error_cnt, n_tests} = {1'b1, 32'h12346bc9, 32'h0, 96'h0};
      {move_length_setting, secondary_span, term_current} = '0;
      {target_speed, speedup_rate, slowdown_rate} = {3{16'h1000}};
      {analog_threshold, analog_sense_input} = {12'h800, 12'h000};
      bad_code = '{2'h3, fms_pkg::CMD_MASK, fms_pkg::CMD_MASK, fms_pkg::CMD_OUT};
      bad_sel = '{3'h1, 3'h0, 3'h5, 3'h2};
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      chk(32'({cmd_ready, cmd_reject, gp_out_current, step_out, dir_ccw, busy, move_done}),
          32'h40);
      // relative feeds, supplied then stored length
      for (int i = 0; i < 6; i++)
      begin
         set_spd();
         len = {27'h0, rnd[20:16]} + 32'h1;
         len = rnd[8] ? -len : len;
         move_length_setting <= i[0] ? len : ~len;
         host.send(fms_pkg::CMD_REL, ~i[0], i[0] ? 32'h0 : len, 3'h1, 2'h0);
         exp_q.push_back(exp_word(len));
         drain("relative");
      end
      // masked sensor feeds over every sensor and condition
      for (int s = 1; s <= 4; s++)
         for (int k = 0; k < 4; k++)
         begin
            set_spd();
            len = {29'h0, rnd[18:16]} + 32'h1;
            len = rnd[9] ? -len : len;
            move_length_setting <= len;
            secondary_span <= {29'h0, rnd[22:20]} + 32'h1;
            set_lvl(3'(s), k == 1 || k == 2);
            host.send(fms_pkg::CMD_MASK, 1'b0, 32'h0, 3'(s), 2'(k));
            if (k < 2)
               exp_q.push_back(exp_word(len) + secondary_span);
            else
            begin
               wait_span(1'b0);
               set_lvl(3'(s), k == 3);
               exp_q.push_back(exp_word(len) + scnt + 32'h1);
            end
            drain("masked");
         end
      // output feeds, low then high
      for (int k = 0; k < 2; k++)
      begin
         set_spd();
         len = {29'h0, rnd[18:16]} + 32'h4;
         len = rnd[9] ? -len : len;
         move_length_setting <= len;
         secondary_span <= {30'h0, rnd[21:20]} + 32'h1;
         host.send(fms_pkg::CMD_OUT, 1'b0, 32'h0, fms_pkg::OUT_ONLY, 2'(k));
         wait_span(1'b1);
         chk({31'h0, gp_out_current}, {31'h0, k == 1});
         repeat (3) @(posedge mclk);
         chk({31'h0, gp_out_current}, {31'h0, k == 0});
         exp_q.push_back(exp_word(len));
         drain("output");
      end
      // illegal commands give one reject pulse and no move
      for (int i = 0; i < 4; i++)
      begin
         host.send(bad_code[i], 1'b0, 32'h0, bad_sel[i], 2'h0);
         w = 0;
         repeat (3)
         begin
            @(posedge mclk);
            w += int'(cmd_reject === 1'b1);
         end
         chk(32'(w), 32'h1);
      end
      drain("reject");
      // queue filled behind a running move
      set_spd();
      for (int i = 0; i < 5; i++)
      begin
         len = i[0] ? -(32'(i) + 32'h3) : 32'(i) + 32'h3;
         host.send(fms_pkg::CMD_REL, 1'b1, len, 3'h1, 2'h0);
         exp_q.push_back(exp_word(len));
      end
      repeat (2) @(posedge mclk);
      chk({31'h0, cmd_ready}, 32'h0);
      drain("queue");
      finish_test();
   end
endmodule // testbench
`default_nettype wire
